// *** tb_vsw_config_regs.sv ***
// Testbench for the switch configuration register bank
`timescale 1ns/1ps
`default_nettype none
module tb_vsw_config_regs;
	logic mclk = 1'b0, rst_n = 1'b0, strap_enable = 1'b1, strap_eq = 1'b1, strap_out_term = 1'b0;
	logic strap_current = 1'b1;
	logic [2:0] strap_a = 3'h5;
	logic [6:0] sa = 7'h4D;
	logic [1:0] strap_source = 2'h2, strap_preemphasis = 2'h1;
	logic scl, sda, oe, fen, sen, ito, oto, ocl, smode;
	logic [1:0] fsel, ssel, pre;
	logic [15:0] cto, eq;
	logic [7:0] ra[8] = '{8'h00, 8'h01, 8'h10, 8'h11, 8'h12, 8'h13, 8'h14, 8'h20};
	logic [7:0] rv[8] = '{8'h40, 8'h40, 8'h01, 8'h00, 8'h00, 8'h00, 8'h00, 8'h03};
	logic [7:0] rm[8] = '{8'h43, 8'h43, 8'h01, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'h0F};
	int n_errors = 0, tests_run = 0;
	always #4 mclk = ~mclk;
	vsw_config_regs #(.PULSE_CYCLES(20)) DUT (.mclk, .rst_n, .scl_in(scl), .sda_in(sda), .sda_out(),
		.sda_oe(oe), .slave_addr_strap_2(strap_a[2]), .slave_addr_strap_1(strap_a[1]),
		.slave_addr_strap_0(strap_a[0]),
		.strap_enable, .strap_source, .strap_eq, .strap_preemphasis, .strap_out_term, .strap_current,
		.fast_path_enable(fen), .fast_path_source_select(fsel), .side_switch_enable(sen),
		.side_switch_source_select(ssel), .input_termination_on(ito), .channel_termination_on(cto),
		.equalization_level_select(eq), .output_preemphasis_level(pre), .output_termination_on(oto),
		.output_current_level(ocl), .serial_mode(smode));
	vsw_i2c_bfm bfm (.mclk, .sda_oe(oe), .scl, .sda);
	task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
		tests_run++;
		if (g !== e) begin
			n_errors++;
			$display("CHECK FAILED %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic tx(input logic [7:0] d);
		logic [8:0] q;
		bfm.xfer({d, 1'b1}, q);
		chk("ack", 16'h0000, 16'(q[0]));
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		bfm.start();
		tx({sa, 1'b0});
		tx(a);
		tx(d);
		bfm.stop();
	endtask
	task automatic rc(input logic [7:0] a, input logic [7:0] e);
		logic [8:0] q;
		bfm.start();
		tx({sa, 1'b0});
		tx(a);
		bfm.start();
		tx({sa, 1'b1});
		bfm.xfer(9'h1FF, q);
		bfm.stop();
		chk("reg", 16'(e), 16'(q[8:1]));
	endtask
	task automatic t_strap;
		logic [8:0] q;
		chk("strap cfg", 16'h01AA, 16'({fen, fsel, eq[0], pre, oto, ocl, smode}));
		bfm.start();
		bfm.xfer(9'h131, q);
		bfm.stop();
		chk("nack", 16'h0001, 16'(q[0]));
		chk("mode", 16'h0000, 16'(smode));
	endtask
	task automatic t_def;
		for (int i = 0; i < 8; i++) rc(ra[i], rv[i]);
		chk("serial cfg", 16'h0186, 16'({smode, fen, fsel, pre, oto, ocl, eq[0]}));
		strap_source = ~strap_source;
		repeat (4) @(posedge mclk);
		chk("strap ignored", 16'h0000, 16'(fsel));
	endtask
	task automatic t_rw;
		for (int i = 0; i < 8; i++) begin
			wr(ra[i], 8'hFF);
			rc(ra[i], rm[i]);
		end
		rc(8'h05, 8'h00);
		chk("all on", 16'h07FF, 16'({fen, fsel, sen, ssel, ito, pre, oto, ocl}));
		chk("eq", 16'hFFFF, eq);
		wr(8'h13, 8'h00);
		chk("eq low", 16'hFF00, eq);
	endtask
	task automatic t_sel;
		for (int c = 0; c < 4; c++) begin
			wr(8'h00, 8'(8'h40 + c));
			wr(8'h01, 8'(c));
			chk("select", 16'({2'h2, 2'(c), 2'(c)}), 16'({fen, sen, fsel, ssel}));
		end
		wr(8'h00, 8'h03);
		chk("standby", 16'h0000, 16'(fen));
	endtask
	task automatic t_addr;
		logic [8:0] q;
		logic [8:0] q2;
		strap_a = 3'h2;
		repeat (4) @(posedge mclk);
		#1;
		bfm.start();
		bfm.xfer(9'h135, q);
		bfm.stop();
		chk("old addr", 16'h0001, 16'(q[0]));
		sa = 7'h4A;
		wr(8'h13, 8'h5A);
		chk("eq split", 16'hFF5A, eq);
		bfm.start();
		tx({sa, 1'b0});
		tx(8'h13);
		bfm.start();
		tx({sa, 1'b1});
		bfm.xfer(9'h1FE, q);
		bfm.xfer(9'h1FF, q2);
		bfm.stop();
		chk("first byte", 16'h005A, 16'(q[8:1]));
		chk("next byte", 16'h005A, 16'(q2[8:1]));
		strap_a = 3'h5;
		sa = 7'h4D;
		repeat (4) @(posedge mclk);
		#1;
	endtask
	task automatic t_pulse;
		int w;
		int lo;
		w = 0;
		lo = 0;
		wr(8'h11, 8'h01);
		wr(8'h12, 8'h00);
		fork
			wr(8'h00, 8'h41);
			begin
				while (cto[0] !== 1'b0 && w < 2000) begin
					@(posedge mclk);
					#1;
					w++;
				end
				if (w == 2000) begin
					chk("pulse start", 16'h0000, 16'(cto[0]));
					complete_run;
				end
				while (cto[0] === 1'b0 && lo < 100) begin
					chk("other channel", 16'h0001, 16'(cto[1]));
					@(posedge mclk);
					#1;
					lo++;
				end
			end
		join
		chk("pulse len", 16'h0001, 16'(lo >= 20 && lo <= 21));
		wr(8'h10, 8'h00);
		chk("term off", 16'h0000, 16'(ito));
	endtask
	task automatic complete_run;
		$display("Checks %0d errors %0d", tests_run, n_errors);
		if (n_errors == 0 && tests_run > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask
	initial begin
		repeat (6) @(posedge mclk);
		#1 rst_n = 1'b1;
		repeat (4) @(posedge mclk);
		#1;
		t_strap();
		t_def();
		t_rw();
		t_sel();
		t_addr();
		t_pulse();
		rst_n = 1'b0;
		repeat (2) @(posedge mclk);
		#1 rst_n = 1'b1;
		repeat (4) @(posedge mclk);
		#1;
		t_def();
		complete_run();
	end
endmodule // tb_vsw_config_regs
`default_nettype wire

// *** vsw_config_regs.v ***
// Configuration register bank of the four-input video link switch
`timescale 1ns/1ps
`default_nettype none
`include "vsw_consts.vh"
module vsw_config_regs #(
	parameter PULSE_CYCLES = `VSW_PULSE_CYCLES
) (
	// Clock and reset
	input wire mclk,
	input wire rst_n,
	// Serial port pins
	input wire scl_in,
	input wire sda_in,
	output wire sda_out,
	output wire sda_oe,
	// Address straps
	input wire slave_addr_strap_2,
	input wire slave_addr_strap_1,
	input wire slave_addr_strap_0,
	// Pin-strap control inputs
	input wire strap_enable,
	input wire [1:0] strap_source,
	input wire strap_eq,
	input wire [1:0] strap_preemphasis,
	input wire strap_out_term,
	input wire strap_current,
	// Configuration outputs
	output reg fast_path_enable,
	output reg [1:0] fast_path_source_select,
	output reg side_switch_enable,
	output reg [1:0] side_switch_source_select,
	output reg input_termination_on,
	output reg [15:0] channel_termination_on,
	output reg [15:0] equalization_level_select,
	output reg [1:0] output_preemphasis_level,
	output reg output_termination_on,
	output reg output_current_level,
	output reg serial_mode
);
	// Synchronisers for pins
	reg [2:0] scl_s_q, sda_s_q, strap_a_q, strap_b_q, strap_c_q;
	reg scl_hi_q, sda_hi_q;
	always @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			scl_s_q <= 3'h7;
			sda_s_q <= 3'h7;
			strap_a_q <= 3'h0;
			strap_b_q <= 3'h0;
			strap_c_q <= 3'h0;
			scl_hi_q <= 1'b1;
			sda_hi_q <= 1'b1;
		end else begin
			scl_s_q <= {scl_s_q[1:0], scl_in};
			sda_s_q <= {sda_s_q[1:0], sda_in};
			strap_a_q <= {slave_addr_strap_2, slave_addr_strap_1, slave_addr_strap_0};
			strap_b_q <= strap_a_q;
			strap_c_q <= strap_b_q;
			if (scl_s_q[1] == scl_s_q[2])
				scl_hi_q <= scl_s_q[2];
			if (sda_s_q[1] == sda_s_q[2])
				sda_hi_q <= sda_s_q[2];
		end
	end
	wire scl_now = (scl_s_q[1] == scl_s_q[2]) ? scl_s_q[2] : scl_hi_q;
	wire sda_now = (sda_s_q[1] == sda_s_q[2]) ? sda_s_q[2] : sda_hi_q;
	// Strap change counts once second and third stages agree
	reg [2:0] strap_q;
	always @(posedge mclk or negedge rst_n) begin
		if (!rst_n)
			strap_q <= 3'h0;
		else if (strap_b_q == strap_c_q)
			strap_q <= strap_c_q;
	end

	wire [7:0] reg_addr, wr_data;
	wire wr_stb, access;
	reg [7:0] rd_data;
	vsw_i2c_slave u_slave (
		.mclk(mclk),
		.rst_n(rst_n),
		.scl_hi(scl_now),
		.scl_rise(scl_now & ~scl_hi_q),
		.scl_fall(~scl_now & scl_hi_q),
		.sda_hi(sda_now),
		.sda_oe(sda_oe),
		.addr_strap(strap_q),
		.reg_addr_q(reg_addr),
		.wr_data_q(wr_data),
		.wr_stb_q(wr_stb),
		.rd_data(rd_data),
		.access_q(access)
	);
	assign sda_out = 1'b0;

	// Serial registers
	reg [7:0] fast_q, side_q, rx_q, plo_q, phi_q, eqlo_q, eqhi_q, tx_q;
	always @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			fast_q <= `VSW_RST_FAST_MODES;
			side_q <= `VSW_RST_SIDE_MODES;
			rx_q <= `VSW_RST_RX_SET;
			plo_q <= `VSW_RST_PULSE;
			phi_q <= `VSW_RST_PULSE;
			eqlo_q <= `VSW_RST_EQ;
			eqhi_q <= `VSW_RST_EQ;
			tx_q <= `VSW_RST_TX_SET;
		end else if (wr_stb) begin
			case (reg_addr)
			`VSW_ADDR_FAST_MODES: fast_q <= wr_data & `VSW_MASK_MODES;
			`VSW_ADDR_SIDE_MODES: side_q <= wr_data & `VSW_MASK_MODES;
			`VSW_ADDR_RX_SET: rx_q <= wr_data & `VSW_MASK_RX_SET;
			`VSW_ADDR_PULSE_LO: plo_q <= wr_data;
			`VSW_ADDR_PULSE_HI: phi_q <= wr_data;
			`VSW_ADDR_EQ_LO: eqlo_q <= wr_data;
			`VSW_ADDR_EQ_HI: eqhi_q <= wr_data;
			`VSW_ADDR_TX_SET: tx_q <= wr_data & `VSW_MASK_TX_SET;
			default: begin
			end
			endcase
		end
	end
	always @* begin
		case (reg_addr)
		`VSW_ADDR_FAST_MODES: rd_data = fast_q;
		`VSW_ADDR_SIDE_MODES: rd_data = side_q;
		`VSW_ADDR_RX_SET: rd_data = rx_q;
		`VSW_ADDR_PULSE_LO: rd_data = plo_q;
		`VSW_ADDR_PULSE_HI: rd_data = phi_q;
		`VSW_ADDR_EQ_LO: rd_data = eqlo_q;
		`VSW_ADDR_EQ_HI: rd_data = eqhi_q;
		`VSW_ADDR_TX_SET: rd_data = tx_q;
		default: rd_data = 8'h00;
		endcase
	end

	// Effective settings: serial after first access, else pin straps
	reg [1:0] src_eff;
	always @* begin
		if (access)
			src_eff = fast_q[1:0];
		else
			src_eff = strap_source;
	end
	reg [1:0] src_prev_q;
	reg [31:0] pulse_cnt_q;
	wire pulse_run = (pulse_cnt_q != 32'h0);
	always @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			src_prev_q <= 2'h0;
			pulse_cnt_q <= 32'h0;
		end else begin
			src_prev_q <= src_eff;
			if (src_prev_q != src_eff)
				pulse_cnt_q <= PULSE_CYCLES;
			else if (pulse_run)
				pulse_cnt_q <= pulse_cnt_q - 32'h1;
		end
	end
	wire [15:0] pulse_sel = {phi_q, plo_q};
	genvar i;
	generate
		for (i = 0; i < 16; i = i + 1) begin : g_term
			always @(posedge mclk or negedge rst_n) begin
				if (!rst_n)
					channel_termination_on[i] <= 1'b1;
				else
					channel_termination_on[i] <= input_termination_on & ~(pulse_run & pulse_sel[i]);
			end
		end
	endgenerate

	always @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			fast_path_enable <= 1'b0;
			fast_path_source_select <= 2'h0;
			side_switch_enable <= 1'b1;
			side_switch_source_select <= 2'h0;
			input_termination_on <= 1'b1;
			equalization_level_select <= 16'h0000;
			output_preemphasis_level <= 2'h0;
			output_termination_on <= 1'b0;
			output_current_level <= 1'b0;
			serial_mode <= 1'b0;
		end else begin
			serial_mode <= access;
			if (access) begin
				fast_path_enable <= fast_q[`VSW_BIT_ENABLE];
				fast_path_source_select <= fast_q[1:0];
				side_switch_enable <= side_q[`VSW_BIT_ENABLE];
				side_switch_source_select <= side_q[1:0];
				input_termination_on <= rx_q[0];
				equalization_level_select <= {eqhi_q, eqlo_q};
				output_preemphasis_level <= tx_q[3:2];
				output_termination_on <= tx_q[1];
				output_current_level <= tx_q[0];
			end else begin
				fast_path_enable <= strap_enable;
				fast_path_source_select <= strap_source;
				side_switch_enable <= 1'b1;
				side_switch_source_select <= strap_source;
				input_termination_on <= 1'b1;
				equalization_level_select <= {16{strap_eq}};
				output_preemphasis_level <= strap_preemphasis;
				output_termination_on <= strap_out_term;
				output_current_level <= strap_current;
			end
		end
	end
endmodule // vsw_config_regs
`default_nettype wire

// *** vsw_config_regs_sva.sv ***
// Assertion checker for the switch configuration register bank
`timescale 1ns/1ps
`default_nettype none
module vsw_config_regs_sva #(
	parameter PULSE_CYCLES = 20
) (
	// Clock and reset
	input wire logic mclk,
	input wire logic rst_n,
	// Serial pins
	input wire logic scl_in,
	input wire logic sda_out,
	input wire logic sda_oe,
	// Pin straps
	input wire logic strap_enable,
	input wire logic [1:0] strap_source,
	input wire logic strap_eq,
	input wire logic strap_current,
	// Configuration
	input wire logic fast_path_enable,
	input wire logic [1:0] fast_path_source_select,
	input wire logic input_termination_on,
	input wire logic [15:0] channel_termination_on,
	input wire logic [15:0] equalization_level_select,
	input wire logic output_current_level,
	input wire logic serial_mode
);
	default clocking @(posedge mclk); endclocking
	default disable iff (!rst_n);
	logic [31:0] low_q;
	// Length of a termination drop on channel zero
	always @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			low_q <= 32'h0;
		end else begin
			low_q <= (channel_termination_on[0] | !input_termination_on) ? 32'h0 : low_q + 32'h1;
		end
	end
	sequence strap_phase;
		!serial_mode ##1 !serial_mode;
	endsequence
	strap_follow_a: assert property (strap_phase |-> fast_path_enable == $past(strap_enable) &&
		fast_path_source_select == $past(strap_source) && output_current_level == $past(strap_current))
		else $error("strap follow");
	strap_eq_a: assert property (strap_phase |-> equalization_level_select == {16{$past(strap_eq)}})
		else $error("strap eq");
	serial_sticky_a: assert property (serial_mode |=> serial_mode)
		else $error("serial mode dropped");
	strap_ignore_a: assert property (serial_mode && scl_in && $past(scl_in) && $changed(strap_source)
		|=> $stable(fast_path_source_select)) else $error("strap used");
	oe_hold_a: assert property (scl_in && $past(scl_in) |-> $stable(sda_oe))
		else $error("data moved while clock high");
	ack_low_a: assert property ($rose(sda_oe) |-> !scl_in)
		else $error("drive began with clock high");
	out_zero_a: assert property (sda_out == 1'b0)
		else $error("data pin driven high");
	pulse_cause_a: assert property ($fell(channel_termination_on[0]) && input_termination_on
		|-> $past(fast_path_source_select, 3) != fast_path_source_select) else $error("pulse cause");
	pulse_max_a: assert property (low_q <= PULSE_CYCLES + 2)
		else $error("pulse too long");
endmodule // vsw_config_regs_sva
bind vsw_config_regs vsw_config_regs_sva #(.PULSE_CYCLES(PULSE_CYCLES)) u_sva (.mclk, .rst_n, .scl_in,
	.sda_out, .sda_oe, .strap_enable, .strap_source, .strap_eq, .strap_current, .fast_path_enable,
	.fast_path_source_select, .input_termination_on, .channel_termination_on, .equalization_level_select,
	.output_current_level, .serial_mode);
`default_nettype wire

// *** vsw_consts.vh ***
// Constants for the video switch configuration register bank
// What this block does
// - Every register readable and writable over serial port
// - Address low three bits from strap pins
// - Serial access disables pin-strap control until reset
// - Fast path enable bit six: standby or on
// - Fast path source select codes pick A-D
// - Side switch enable bit six: off or on
// - Side switch source select codes pick A-D
// - Input termination bit zero, reset one
// - Per-channel termination pulse field, sixteen bits
// - Sixteen-bit equalization select, resets zero
// - Pulse bit: termination off 100 ms on switch
// - Equalization bit: 6 dB or 12 dB
// - Pre-emphasis code selects 0/2/4/6 dB
// - Current level bit: 10 or 20 mA
`ifndef VSW_CONSTS_VH
`define VSW_CONSTS_VH
`define VSW_ADDR_FAST_MODES 8'h00
`define VSW_ADDR_SIDE_MODES 8'h01
`define VSW_ADDR_RX_SET 8'h10
`define VSW_ADDR_PULSE_LO 8'h11
`define VSW_ADDR_PULSE_HI 8'h12
`define VSW_ADDR_EQ_LO 8'h13
`define VSW_ADDR_EQ_HI 8'h14
`define VSW_ADDR_TX_SET 8'h20
`define VSW_RST_FAST_MODES 8'h40
`define VSW_RST_SIDE_MODES 8'h40
`define VSW_RST_RX_SET 8'h01
`define VSW_RST_PULSE 8'h00
`define VSW_RST_EQ 8'h00
`define VSW_RST_TX_SET 8'h03
`define VSW_MASK_MODES 8'h43
`define VSW_MASK_RX_SET 8'h01
`define VSW_MASK_TX_SET 8'h0F
`define VSW_BIT_ENABLE 6
`define VSW_SLAVE_ADDR_HI 4'h9
`define VSW_CLK_MHZ 125
`define VSW_PULSE_MS 100
`define VSW_PULSE_CYCLES (`VSW_PULSE_MS * 1000 * `VSW_CLK_MHZ)
`endif

// *** vsw_i2c_bfm.sv ***
// Two-wire serial master model for the switch slave port
`timescale 1ns/1ps
`default_nettype none
module vsw_i2c_bfm (
	// Clock
	input wire logic mclk,
	// Bus
	input wire logic sda_oe,
	output logic scl,
	output wire logic sda
);
	logic drv = 1'b1;
	// Pull-up: line low when either side pulls
	assign sda = drv & ~sda_oe;
	initial scl = 1'b1;
	task automatic hp;
		repeat (10) @(posedge mclk);
		#1;
	endtask
	task automatic start;
		drv = 1'b1;
		hp;
		scl = 1'b1;
		hp;
		drv = 1'b0;
		hp;
		scl = 1'b0;
		hp;
	endtask
	task automatic stop;
		drv = 1'b0;
		hp;
		scl = 1'b1;
		hp;
		drv = 1'b1;
		hp;
	endtask
	// Eight bits then acknowledge, most significant first
	task automatic xfer(input logic [8:0] d, output logic [8:0] q);
		for (int i = 8; i >= 0; i--) begin
			drv = d[i];
			hp;
			scl = 1'b1;
			hp;
			q[i] = sda;
			scl = 1'b0;
			hp;
		end
	endtask
endmodule // vsw_i2c_bfm
`default_nettype wire

// *** vsw_i2c_slave.v ***
// Two-wire serial slave byte engine with register address pointer
`timescale 1ns/1ps
`default_nettype none
`include "vsw_consts.vh"
module vsw_i2c_slave (
	// Clock and reset
	input wire mclk,
	input wire rst_n,
	// Serial pins, already synchronised
	input wire scl_hi,
	input wire scl_rise,
	input wire scl_fall,
	input wire sda_hi,
	output reg sda_oe,
	// Strap bits
	input wire [2:0] addr_strap,
	// Register access
	output reg [7:0] reg_addr_q,
	output reg [7:0] wr_data_q,
	output reg wr_stb_q,
	input wire [7:0] rd_data,
	output reg access_q
);
	localparam ST_IDLE = 6'h01, ST_ADDR = 6'h02, ST_ACK = 6'h04, ST_RX = 6'h08, ST_TX = 6'h10,
		ST_MACK = 6'h20;
	reg [5:0] st_q;
	reg [7:0] sh_q;
	reg [3:0] cnt_q;
	reg rw_q;
	reg ptr_q;
	reg sda_d1_q;
	wire start = scl_hi & sda_d1_q & ~sda_hi;
	wire stop = scl_hi & ~sda_d1_q & sda_hi;
	always @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			st_q <= ST_IDLE;
			sh_q <= 8'h00;
			cnt_q <= 4'h0;
			rw_q <= 1'b0;
			ptr_q <= 1'b0;
			sda_d1_q <= 1'b1;
			sda_oe <= 1'b0;
			reg_addr_q <= 8'h00;
			wr_data_q <= 8'h00;
			wr_stb_q <= 1'b0;
			access_q <= 1'b0;
		end else begin
			sda_d1_q <= sda_hi;
			wr_stb_q <= 1'b0;
			if (start) begin
				st_q <= ST_ADDR;
				cnt_q <= 4'h0;
				sda_oe <= 1'b0;
			end else if (stop) begin
				st_q <= ST_IDLE;
				sda_oe <= 1'b0;
			end else begin
				case (st_q)
				ST_IDLE: begin
				end
				ST_ADDR, ST_RX: begin
					if (scl_rise) begin
						sh_q <= {sh_q[6:0], sda_hi};
						cnt_q <= cnt_q + 4'h1;
					end
					if (scl_fall && cnt_q == 4'h8) begin
						cnt_q <= 4'h0;
						if (st_q == ST_ADDR) begin
							if (sh_q[7:1] == {`VSW_SLAVE_ADDR_HI, addr_strap}) begin
								rw_q <= sh_q[0];
								ptr_q <= ~sh_q[0];
								access_q <= 1'b1;
								sda_oe <= 1'b1;
								st_q <= ST_ACK;
							end else begin
								st_q <= ST_IDLE;
							end
						end else begin
							if (ptr_q) begin
								reg_addr_q <= sh_q;
								ptr_q <= 1'b0;
							end else begin
								wr_data_q <= sh_q;
								wr_stb_q <= 1'b1;
							end
							sda_oe <= 1'b1;
							st_q <= ST_ACK;
						end
					end
				end
				ST_ACK: begin
					if (scl_fall) begin
						cnt_q <= 4'h0;
						if (rw_q) begin
							sh_q <= rd_data;
							sda_oe <= ~rd_data[7];
							st_q <= ST_TX;
						end else begin
							sda_oe <= 1'b0;
							st_q <= ST_RX;
						end
					end
				end
				ST_TX: begin
					if (scl_fall) begin
						cnt_q <= cnt_q + 4'h1;
						if (cnt_q == 4'h7) begin
							sda_oe <= 1'b0;
							st_q <= ST_MACK;
						end else begin
							sda_oe <= ~sh_q[6];
							sh_q <= {sh_q[6:0], 1'b0};
						end
					end
				end
				ST_MACK: begin
					if (scl_rise) begin
						st_q <= sda_hi ? ST_IDLE : ST_ACK;
						rw_q <= 1'b1;
					end
				end
				default: st_q <= ST_IDLE;
				endcase
			end
		end
	end
endmodule // vsw_i2c_slave
`default_nettype wire
